// ==== design/charger_control_register_map.sv ====
// charger_control_register_map: user register bank of a single-cell charger
// assumes analog loops supply live status and take the control struct
// Overview of operation
// - registers at 00..04, live at 10, id alias 3b
// - extended variant adds registers 05 and 06
// - writing 1 to bit 7 restarts watchdog
// - bit 7 reads supply request pin level
// - bit 6 gates status pin low while charging
// - bits 5:4 phase, bits 2:0 fault code
// - bit 3 reads one in boost mode
// - second register bits 7:6 set input cap
// - bits 5:4 pick weak battery threshold
// - bit 3 termination enable, bit 2 disable
// - second register resets to 30h
// - serial slave answers at address byte d6
`default_nettype none
`include "charger_map.svh"
module charger_control_register_map #(
    parameter bit          EXTENDED_VARIANT = 1'b1,
    parameter logic [7:0]  PART_ID          = 8'h5a,  // arbitrary value
    parameter logic [32:0] WATCHDOG_CYCLES  = 33'(`WATCHDOG_CYCLES)
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_oe,
    input  wire charger_pkg::charger_status_t status,
    output charger_pkg::charger_ctrl_t    ctrl,
    output logic                          stat_pull_low,
    output logic                          watchdog_expired
);
    charger_pkg::reg_req_t req;
    logic [7:0]  rd_data_r;
    logic        stat_enable_r;
    logic [7:0]  limit_r;
    logic [7:0]  float_r;
    logic [6:0]  current_r;
    logic [6:0]  weak_r;
    logic [6:0]  safety_r;
    logic [32:0] wd_count_r;
    logic [15:0] blink_count_r;
    logic        blink_r;
    logic        blink_tick;
    logic        param_reset;
    logic        wd_restart;

    serial_target u_serial (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe   (sda_oe),
        .req      (req),
        .rd_data  (rd_data_r)
    );

    function automatic logic is_ext(input logic [7:0] a);
        return a == `REG_WEAK_SOURCE_CONFIG || a == `REG_MAX_LIMIT_LOCK;
    endfunction : is_ext

    function automatic logic wr_hit(input charger_pkg::reg_req_t r, input logic [7:0] a);
        return r.wr && r.addr == a && (EXTENDED_VARIANT || !is_ext(a));
    endfunction : wr_hit

    assign wd_restart  = wr_hit(req, `REG_STATUS_AND_TIMER)
                         && req.wdata[`BIT_WATCHDOG_RESTART];
    assign param_reset = wr_hit(req, `REG_CHARGE_CURRENT_SETTING)
                         && req.wdata[`BIT_PARAM_RESET];

    // read mux, zero for anything not implemented except bits 7 and 3 of register 04, which read one
    function automatic logic [7:0] read_value(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `REG_STATUS_AND_TIMER:        v = {status.host_supply_request_pin_level,
                                               stat_enable_r, status.charge_phase,
                                               status.boost_active,
                                               status.fault_code};
            `REG_INPUT_LIMIT_CONFIG:      v = limit_r;
            `REG_FLOAT_VOLTAGE_SETTING:   v = float_r;
            `REG_PART_IDENTIFICATION,
            `REG_PART_IDENTIFICATION_ALT: v = PART_ID;
            `REG_CHARGE_CURRENT_SETTING:  v = {1'b1, current_r[6:4], 1'b1, current_r[2:0]};
            `REG_WEAK_SOURCE_CONFIG:      v = EXTENDED_VARIANT ?
                                              {1'b0, weak_r[6:5], status.special_charger_active,
                                               status.disable_pin_level, weak_r[2:0]} : 8'h00;
            `REG_MAX_LIMIT_LOCK:          v = EXTENDED_VARIANT ? {1'b0, safety_r} : 8'h00;
            `REG_LIVE_CONDITION_FLAGS:    v = status.live_flags;
            default:                      v = 8'h00;
        endcase
        return v;
    endfunction : read_value

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h00;
        end else if (req.rd) begin
            rd_data_r <= read_value(req.addr);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_enable_r <= `RST_STATUS_ENABLE;
        end else if (wr_hit(req, `REG_STATUS_AND_TIMER)) begin
            stat_enable_r <= req.wdata[`BIT_STAT_ENABLE];
        end
    end

    // charge parameters; a parameter reset leaves the safety limits alone
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_r   <= `RST_INPUT_LIMIT_CONFIG;
            float_r   <= `RST_FLOAT_VOLTAGE_SETTING;
            current_r <= 7'(`RST_CHARGE_CURRENT_SETTING);
        end else if (param_reset) begin
            limit_r   <= `RST_INPUT_LIMIT_CONFIG;
            float_r   <= `RST_FLOAT_VOLTAGE_SETTING;
            current_r <= 7'(`RST_CHARGE_CURRENT_SETTING);
        end else begin
            if (wr_hit(req, `REG_INPUT_LIMIT_CONFIG)) begin
                limit_r <= req.wdata;
            end
            if (wr_hit(req, `REG_FLOAT_VOLTAGE_SETTING)) begin
                float_r <= req.wdata;
            end
            if (wr_hit(req, `REG_CHARGE_CURRENT_SETTING)) begin
                current_r <= req.wdata[6:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            weak_r   <= 7'(`RST_WEAK_SOURCE_CONFIG);
            safety_r <= 7'(`RST_MAX_LIMIT_LOCK);
        end else begin
            if (wr_hit(req, `REG_WEAK_SOURCE_CONFIG)) begin
                weak_r <= req.wdata[6:0];
            end
            if (wr_hit(req, `REG_MAX_LIMIT_LOCK)) begin
                safety_r <= req.wdata[6:0];
            end
        end
    end

    // safety watchdog, restart wins over expiry
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_count_r       <= 33'h0;
            watchdog_expired <= 1'b0;
        end else if (wd_restart) begin
            wd_count_r       <= 33'h0;
            watchdog_expired <= 1'b0;
        end else if (wd_count_r >= WATCHDOG_CYCLES - 33'h1) begin
            watchdog_expired <= 1'b1;
        end else begin
            wd_count_r <= wd_count_r + 33'h1;
        end
    end

    // blink divider for fault signalling on the status pin
    assign blink_tick = (blink_count_r == 16'(`STAT_BLINK_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_count_r <= 16'h0000;
            blink_r       <= 1'b0;
        end else if (blink_tick) begin
            blink_count_r <= 16'h0000;
            blink_r       <= !blink_r;
        end else begin
            blink_count_r <= blink_count_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_pull_low <= 1'b0;
        end else begin
            stat_pull_low <= (stat_enable_r && status.charge_phase == `PHASE_CHARGING)
                             || (status.charge_phase == `PHASE_FAULT && blink_r);
        end
    end

    always_comb begin
        ctrl                             = '0;
        ctrl.input_current_cap           = limit_r[7:6];
        ctrl.weak_battery_threshold      = limit_r[5:4];
        ctrl.end_of_charge_cutoff_enable = limit_r[3];
        ctrl.charger_disable             = limit_r[2];
        ctrl.high_impedance              = limit_r[1];
        ctrl.boost_request               = limit_r[0];
        ctrl.float_voltage               = float_r;
        ctrl.charge_current              = {1'b0, current_r};
        ctrl.weak_source                 = {1'b0, weak_r};
        ctrl.max_limit                   = {1'b0, safety_r};
    end

    // helper for the reset value check
    logic limit_touched_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_touched_r <= 1'b0;
        end else if (wr_hit(req, `REG_INPUT_LIMIT_CONFIG)) begin
            limit_touched_r <= 1'b1;
        end
    end

    sequence s_status_read;
        req.rd && req.addr == `REG_STATUS_AND_TIMER;
    endsequence

    property p_wd_restart;
        @(posedge core_clk) disable iff (!rst_n)
        wd_restart |=> (wd_count_r == 33'h0) ##1 (wd_count_r == 33'h1 || wd_restart);
    endproperty
    a_wd_restart: assert property (p_wd_restart)
        else $error("watchdog not restarted by write of one");

    property p_wd_zero_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_hit(req, `REG_STATUS_AND_TIMER) && !req.wdata[7] && !watchdog_expired
         && wd_count_r < WATCHDOG_CYCLES - 33'h1)
        |=> wd_count_r == $past(wd_count_r) + 33'h1;
    endproperty
    a_wd_zero_ignored: assert property (p_wd_zero_ignored)
        else $error("writing zero disturbed the watchdog");

    property p_wd_expire;
        @(posedge core_clk) disable iff (!rst_n)
        (wd_count_r == WATCHDOG_CYCLES - 33'h1 && !wd_restart) |=> watchdog_expired;
    endproperty
    a_wd_expire: assert property (p_wd_expire)
        else $error("watchdog did not expire at its count");

    property p_status_read;
        @(posedge core_clk) disable iff (!rst_n)
        s_status_read |=> rd_data_r == {$past(status.host_supply_request_pin_level),
                                        $past(stat_enable_r), $past(status.charge_phase),
                                        $past(status.boost_active), $past(status.fault_code)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status register read value wrong");

    property p_stat_pin;
        @(posedge core_clk) disable iff (!rst_n)
        (status.charge_phase != `PHASE_FAULT)
        |=> stat_pull_low == ($past(stat_enable_r)
                              && $past(status.charge_phase) == `PHASE_CHARGING);
    endproperty
    a_stat_pin: assert property (p_stat_pin)
        else $error("status pin does not follow enable and phase");

    property p_limit_write;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_hit(req, `REG_INPUT_LIMIT_CONFIG) && !param_reset)
        |=> {ctrl.input_current_cap, ctrl.weak_battery_threshold,
             ctrl.end_of_charge_cutoff_enable, ctrl.charger_disable} == $past(req.wdata[7:2]);
    endproperty
    a_limit_write: assert property (p_limit_write)
        else $error("second control register fields not applied");

    property p_limit_reset;
        @(posedge core_clk) disable iff (!rst_n)
        !limit_touched_r |-> limit_r == 8'h30 && ctrl.weak_battery_threshold == 2'h3;
    endproperty
    a_limit_reset: assert property (p_limit_reset)
        else $error("second control register lost its reset value");

    property p_id_alias;
        @(posedge core_clk) disable iff (!rst_n)
        (req.rd && (req.addr == `REG_PART_IDENTIFICATION_ALT
                    || req.addr == `REG_PART_IDENTIFICATION)) |=> rd_data_r == PART_ID;
    endproperty
    a_id_alias: assert property (p_id_alias)
        else $error("identification not returned at both addresses");

    property p_unmapped;
        @(posedge core_clk) disable iff (!rst_n)
        (req.rd && req.addr > 8'h06 && req.addr != 8'h10 && req.addr != 8'h3b)
        |=> rd_data_r == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");

    property p_unmapped_write;
        @(posedge core_clk) disable iff (!rst_n)
        (req.wr && req.addr > 8'h06)
        |=> $stable(limit_r) && $stable(float_r) && $stable(current_r) && $stable(weak_r)
            && $stable(safety_r) && $stable(stat_enable_r);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("unmapped write disturbed a register");

    property p_basic_variant;
        @(posedge core_clk) disable iff (!rst_n)
        (!EXTENDED_VARIANT && req.rd && is_ext(req.addr)) |=> rd_data_r == 8'h00;
    endproperty
    a_basic_variant: assert property (p_basic_variant)
        else $error("basic variant exposes extended register");
endmodule : charger_control_register_map
`default_nettype wire

// ==== design/charger_map.svh ====
// charger_map.svh: register offsets, fields, reset values and timing counts
// assumes inclusion by the register bank and the serial front end
`ifndef CHARGER_MAP_SVH
`define CHARGER_MAP_SVH

// register byte addresses
`define REG_STATUS_AND_TIMER        8'h00
`define REG_INPUT_LIMIT_CONFIG      8'h01
`define REG_FLOAT_VOLTAGE_SETTING   8'h02
`define REG_PART_IDENTIFICATION     8'h03
`define REG_PART_IDENTIFICATION_ALT 8'h3b
`define REG_CHARGE_CURRENT_SETTING  8'h04
`define REG_WEAK_SOURCE_CONFIG      8'h05
`define REG_MAX_LIMIT_LOCK          8'h06
`define REG_LIVE_CONDITION_FLAGS    8'h10

// reset values
`define RST_STATUS_ENABLE           1'b1
`define RST_INPUT_LIMIT_CONFIG      8'h30
`define RST_FLOAT_VOLTAGE_SETTING   8'h0a
`define RST_CHARGE_CURRENT_SETTING  8'h89
`define RST_WEAK_SOURCE_CONFIG      8'h24
`define RST_MAX_LIMIT_LOCK          8'h40

// field positions
`define BIT_WATCHDOG_RESTART        7
`define BIT_STAT_ENABLE             6
`define BIT_PARAM_RESET             7

// charge phase codes
`define PHASE_READY                 2'h0
`define PHASE_CHARGING              2'h1
`define PHASE_DONE                  2'h2
`define PHASE_FAULT                 2'h3

// serial slave address (7 bits), byte d6 with write bit
`define SLAVE_ADDRESS               7'h6b

// timing
`define CLK_HZ                      250000000
`define WATCHDOG_TIME_S             32
`define WATCHDOG_CYCLES             (64'(`WATCHDOG_TIME_S) * 64'(`CLK_HZ))
`define STAT_BLINK_TIME_NS          4000
`define CLK_PERIOD_NS               4
`define STAT_BLINK_CYCLES           (`STAT_BLINK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ==== design/charger_pkg.sv ====
// charger_pkg: carrier types shared by the register bank and serial front end
// assumes no other package
`default_nettype none
package charger_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       host_supply_request_pin_level;
        logic [1:0] charge_phase;
        logic       boost_active;
        logic [2:0] fault_code;
        logic       special_charger_active;
        logic       disable_pin_level;
        logic [7:0] live_flags;
    } charger_status_t;

    typedef struct packed {
        logic [1:0] input_current_cap;
        logic [1:0] weak_battery_threshold;
        logic       end_of_charge_cutoff_enable;
        logic       charger_disable;
        logic       high_impedance;
        logic       boost_request;
        logic [7:0] float_voltage;
        logic [7:0] charge_current;
        logic [7:0] weak_source;
        logic [7:0] max_limit;
    } charger_ctrl_t;
endpackage : charger_pkg
`default_nettype wire

// ==== design/serial_target.sv ====
// serial_target: two-wire slave front end, oversampled on core_clk
// assumes scl and sda inputs already synchronous to core_clk
`default_nettype none
`include "charger_map.svh"
module serial_target (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_oe,
    output charger_pkg::reg_req_t    req,
    input  wire logic [7:0]          rd_data
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV  = 3'b001,
        ST_PTR  = 3'b011,
        ST_WR   = 3'b010,
        ST_RD   = 3'b110
    } link_state_t;

    link_state_t state_r;
    logic        scl_r;
    logic        sda_r;
    logic [3:0]  cnt_r;
    logic [7:0]  sh_r;
    logic [7:0]  ptr_r;
    logic        start_ev;
    logic        stop_ev;
    logic        rise;
    logic        fall;
    logic        dev_match;

    assign start_ev  = scl_in && scl_r && sda_r && !sda_in;
    assign stop_ev   = scl_in && scl_r && !sda_r && sda_in;
    assign rise      = scl_in && !scl_r;
    assign fall      = !scl_in && scl_r;
    assign dev_match = (sh_r[7:1] == `SLAVE_ADDRESS);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl_in;
            sda_r <= sda_in;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            sh_r    <= 8'h00;
            ptr_r   <= 8'h00;
        end else if (start_ev) begin
            state_r <= ST_DEV;
            cnt_r   <= 4'h0;
        end else if (stop_ev) begin
            state_r <= ST_IDLE;
        end else if (rise && state_r != ST_IDLE) begin
            if (cnt_r != 4'h8) begin
                sh_r  <= {sh_r[6:0], sda_in};
                cnt_r <= cnt_r + 4'h1;
            end else begin
                cnt_r <= 4'h0;
                case (state_r)
                    ST_DEV:  state_r <= !dev_match ? ST_IDLE : (sh_r[0] ? ST_RD : ST_PTR);
                    ST_PTR:  begin
                        state_r <= ST_WR;
                        ptr_r   <= sh_r;
                    end
                    ST_WR:   ptr_r <= ptr_r + 8'h01;
                    ST_RD:   begin
                        if (sda_in) begin
                            state_r <= ST_IDLE;
                        end
                        ptr_r <= ptr_r + 8'h01;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // read request on the ack clock so data settle before the next fall
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else begin
            req.wr    <= fall && state_r == ST_WR && cnt_r == 4'h8;
            req.wdata <= sh_r;
            req.rd    <= rise && cnt_r == 4'h8 && !start_ev && !stop_ev
                         && ((state_r == ST_DEV && dev_match && sh_r[0])
                             || (state_r == ST_RD && !sda_in));
            req.addr  <= (rise && state_r == ST_RD) ? ptr_r + 8'h01 : ptr_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else if (start_ev || stop_ev) begin
            sda_oe <= 1'b0;
        end else if (fall) begin
            if (cnt_r == 4'h8) begin
                sda_oe <= (state_r == ST_DEV && dev_match)
                          || state_r == ST_PTR || state_r == ST_WR;
            end else if (state_r == ST_RD) begin
                sda_oe <= !rd_data[3'(4'h7 - cnt_r)];
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    property p_addr_ack;
        @(posedge core_clk) disable iff (!rst_n)
        (fall && cnt_r == 4'h8 && state_r == ST_DEV && !start_ev && !stop_ev)
        |=> (sda_oe == $past(dev_match));
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge does not follow address match");
endmodule : serial_target
`default_nettype wire

// ==== verif/charger_control_register_map_tb.sv ====
// charger_control_register_map_tb: register bank driven over the two-wire port
// assumes host_i2c_model as bus master and a pulled-up data wire
`default_nettype none
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module charger_control_register_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  ID   = 8'hc6;  // arbitrary value
    localparam logic [32:0] WDOG = 33'd3000;
    logic                          core_clk, rst_n, scl, host_oe, dev_oe, sda;
    logic                          stat_pull_low, watchdog_expired, ok;
    logic [7:0]                    rd, v;
    charger_pkg::charger_status_t  status;
    charger_pkg::charger_ctrl_t    ctrl;
    int                            n_errors = 0, num_checks = 0, cycles = 0, n;

    assign sda = ~(host_oe | dev_oe);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    charger_control_register_map #(.PART_ID(ID), .WATCHDOG_CYCLES(WDOG))
        u_charger_control_register_map (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda), .sda_oe(dev_oe), .status(status), .ctrl(ctrl),
        .stat_pull_low(stat_pull_low), .watchdog_expired(watchdog_expired));
    host_i2c_model u_host_i2c_model (.core_clk(core_clk), .sda_in(sda), .scl(scl),
        .sda_oe(host_oe));

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host_i2c_model.write_reg(a, d, ok);
        `CHECK(ok, 1'b1);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_host_i2c_model.read_reg(a, rd, ok);
        `CHECK(ok, 1'b1);
        `CHECK(rd, exp);
    endtask : rd_chk

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        rst_n  = 1'b0;
        status = '0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd_chk(8'h01, 8'h30);
        rd_chk(8'h02, 8'h0a);
        rd_chk(8'h04, 8'h89);
        `CHECK({ctrl.float_voltage, ctrl.charge_current}, 16'h0a09);
        `CHECK({ctrl.input_current_cap, ctrl.weak_battery_threshold}, 4'h3);
        `CHECK({ctrl.end_of_charge_cutoff_enable, ctrl.charger_disable}, 2'h0);
        for (int i = 0; i < 4; i++) begin
            v = {2'(i), 2'(3 - i), i[0], ~i[0], 2'b00};
            wr(8'h01, v);
            rd_chk(8'h01, v);
            `CHECK(ctrl.input_current_cap, v[7:6]);
            `CHECK(ctrl.weak_battery_threshold, v[5:4]);
            `CHECK({ctrl.end_of_charge_cutoff_enable, ctrl.charger_disable}, v[3:2]);
        end
        // every phase code with pin, boost and fault fields varied
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            status.charge_phase                  <= 2'(i);
            status.host_supply_request_pin_level <= i[0];
            status.boost_active                  <= i[1];
            status.fault_code                    <= 3'(i + 3);
            rd_chk(8'h00, {i[0], 1'b1, 2'(i), i[1], 3'(i + 3)});
        end
        status.charge_phase <= 2'h1;
        repeat (4) @(posedge core_clk);
        `CHECK(stat_pull_low, 1'b1);
        wr(8'h00, 8'h00);
        repeat (4) @(posedge core_clk);
        `CHECK(stat_pull_low, 1'b0);
        rd_chk(8'h00, 8'h9e);
        // fault still pulses the pin with the enable off
        status.charge_phase <= 2'h3;
        n = 0;
        repeat (2100) begin
            @(posedge core_clk);
            n += int'(stat_pull_low === 1'b1);
        end
        `CHECK(n > 800 && n < 1300, 1'b1);
        `CHECK(watchdog_expired, 1'b1);
        wr(8'h00, 8'h40);
        `CHECK(watchdog_expired, 1'b1);
        wr(8'h00, 8'hc0);
        `CHECK(watchdog_expired, 1'b0);
        // a zero write while running must not push the expiry out
        wr(8'h00, 8'h40);
        `CHECK(watchdog_expired, 1'b0);
        n = 0;
        while (watchdog_expired !== 1'b1 && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        `CHECK(n > 2400 && n <= 2500, 1'b1);
        rd_chk(8'h03, ID);
        rd_chk(8'h3b, ID);
        status.live_flags <= 8'ha5;
        rd_chk(8'h10, 8'ha5);
        wr(8'h06, 8'h35);
        rd_chk(8'h06, 8'h35);
        `CHECK(ctrl.max_limit, 8'h35);
        wr(8'h05, 8'h63);
        rd_chk(8'h05, 8'h63);
        `CHECK(ctrl.weak_source, 8'h63);
        wr(8'h3a, 8'hff);
        rd_chk(8'h3a, 8'h00);
        rd_chk(8'h01, v);
        u_host_i2c_model.probe(8'hd4, ok);
        `CHECK(ok, 1'b0);
        u_host_i2c_model.probe(8'hd6, ok);
        `CHECK(ok, 1'b1);
        print_verdict();
    end
endmodule : charger_control_register_map_tb
`default_nettype wire

// ==== verif/host_i2c_model.sv ====
// host_i2c_model: two-wire bus master that reaches the charger register bank
// assumes the bench resolves the open-drain data wire with a pull-up
`default_nettype none
module host_i2c_model #(
    parameter int         HALF     = 8,
    parameter logic [6:0] DEV_ADDR = 7'h6b
) (
    input  wire logic core_clk,
    input  wire logic sda_in,
    output var logic  scl,
    output var logic  sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end

    // data moves one cycle after the clock so no false start or stop is seen
    task automatic phase(input logic c, input logic d);
        @(posedge core_clk);
        scl <= c;
        @(posedge core_clk);
        sda_oe <= ~d;
        repeat (HALF - 2) @(posedge core_clk);
    endtask : phase

    // clock drops first so a held acknowledge is let go before a repeated start
    task automatic start_cond();
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b0);
    endtask : start_cond

    task automatic stop_cond();
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask : stop_cond

    // msb first, ninth clock returns the ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            phase(1'b0, b[i]);
            phase(1'b1, b[i]);
        end
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        #1 ack = ~sda_in;
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            phase(1'b0, 1'b1);
            phase(1'b1, 1'b1);
            #1 b[i] = sda_in;
        end
        phase(1'b0, last);
        phase(1'b1, last);
    endtask : recv_byte

    task automatic probe(input logic [7:0] abyte, output logic ack);
        start_cond();
        send_byte(abyte, ack);
        stop_cond();
    endtask : probe

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, a0);
        send_byte(a, a1);
        send_byte(d, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, a0);
        send_byte(a, a1);
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, a2);
        recv_byte(1'b1, d);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : read_reg
endmodule : host_i2c_model
`default_nettype wire
